// [src/msd_decoder.sv]
// core memory-space decoder: internal ram, sfr space, extended ram, code store
// assumes the core issues one request per ready cycle on i_mclk
//
// Overview of operation
// - 256 bytes of general ram cover internal addresses 0x00 to 0xff.
// - direct accesses to 0x80..0xff reach sfrs, never the ram bytes there.
// - indirect accesses to 0x80..0xff reach general ram, never sfrs.
// - direct and indirect accesses below 0x80 reach the same ram bytes.
// - bit address below 0x80 maps to byte 0x20 plus addr>>3, bit addr[2:0].
// - bit-addressable sfrs can be read and changed bit by bit.
// - 2 kB extended ram, 0 to 0x7ff, reached only by extended modes.
// - no external code or data cycles; port pins never form a bus.
// - 62 kB code store, readable as data only by code-indirect reads.
// - three 16-bit timers, each may count external events instead.
// - third timer count captured into two byte registers on external edge.
// - per-source high/low priority; supply interrupt sits above both tiers.
// - 20 gpio pins over three bit-addressable port registers.
// - per-pin pull-up enable; disabled pull-up leaves the pin open drain.
// - core power mode register at 0x87, byte access only.
// - extended power control register at 0xc5.
// - each of two serial ports has a config and a buffer register.
`include "msd_params.svh"
`default_nettype none
module msd_decoder (
  input  wire logic               i_mclk,
  input  wire logic               i_rst_b,
  input  wire msd_pkg::msd_req_t  i_req,
  output logic                    o_ready,
  output var msd_pkg::msd_rsp_t   o_rsp,
  input  wire msd_pkg::msd_load_t i_code_load,
  input  wire logic [19:0]        i_gpio_in,
  output logic      [19:0]        o_gpio_out,
  output logic      [19:0]        o_gpio_oe_b,
  output logic      [19:0]        o_gpio_pullup,
  input  wire logic [2:0]         i_tmr_evt,
  input  wire logic               i_cap_trig,
  input  wire logic [7:0]         i_irq_req,
  input  wire logic               i_supply_irq,
  output var msd_pkg::msd_irq_t   o_irq,
  input  wire msd_pkg::msd_ser_t  i_ser_rx,
  output var msd_pkg::msd_ser_t   o_ser_tx,
  output logic      [15:0]        o_ser_cfg,
  output logic      [7:0]         o_core_pwr,
  output logic      [7:0]         o_ext_pwr
);
  localparam logic [1:0] SRC_REG  = 2'h0;
  localparam logic [1:0] SRC_IRAM = 2'h1;
  localparam logic [1:0] SRC_EXTENDED_RAM = 2'h2;
  localparam logic [1:0] SRC_CODE = 2'h3;

  msd_pkg::msd_state_t state_r, state_nxt;
  logic [7:0]  pend_addr_r, pend_addr_nxt;
  logic [2:0]  pend_pos_r, pend_pos_nxt, rsp_pos_r, rsp_pos_nxt;
  logic        pend_val_r, pend_val_nxt, rsp_valid_r, rsp_valid_nxt;
  logic        rsp_bit_r, rsp_bit_nxt;
  logic [1:0]  rsp_src_r, rsp_src_nxt;
  logic [7:0]  rsp_reg_r, rsp_reg_nxt;
  logic        take, ram_en, ram_we, extended_ram_en, extended_ram_we, code_en, sfr_we;
  logic [7:0]  ram_addr, ram_wd, sfr_wa, sfr_wd, sfr_byte, iram_rd, extended_ram_rd, code_rd, rsp_byte;
  logic [23:0] s1_r, s2_r;
  logic [3:0]  s3_r, edge_s;
  logic [19:0] gpio_r, gpio_nxt, pu_r, pu_nxt;
  logic [7:0]  tctl_r, tctl_nxt, prio_r, prio_nxt, cpwr_r, cpwr_nxt, epwr_r, epwr_nxt;
  logic [15:0] tmr_r [3];
  logic [15:0] tmr_nxt [3];
  logic [15:0] cap_r, cap_nxt;
  logic [7:0]  scfg_r [2];
  logic [7:0]  scfg_nxt [2];
  logic [7:0]  sbuf_r [2];
  logic [7:0]  sbuf_nxt [2];
  msd_pkg::msd_ser_t tx_r, tx_nxt;
  msd_pkg::msd_irq_t irq_r, irq_nxt;

  // sfr read view; timer bytes sit in pairs from the timer base
  function automatic logic [7:0] sfr_read(input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      `MSD_SFR_GPIO0:    d = s2_r[7:0];
      `MSD_SFR_GPIO1:    d = s2_r[15:8];
      `MSD_SFR_GPIO2:    d = {4'h0, s2_r[19:16]};
      `MSD_SFR_PU0:      d = pu_r[7:0];
      `MSD_SFR_PU1:      d = pu_r[15:8];
      `MSD_SFR_PU2:      d = {4'h0, pu_r[19:16]};
      `MSD_SFR_TMR_CTL:  d = tctl_r;
      `MSD_SFR_CAP_LO:   d = cap_r[7:0];
      `MSD_SFR_CAP_HI:   d = cap_r[15:8];
      `MSD_SFR_IRQ_PRIO: d = prio_r;
      `MSD_SFR_SER0_CFG: d = scfg_r[0];
      `MSD_SFR_SER0_BUF: d = sbuf_r[0];
      `MSD_SFR_SER1_CFG: d = scfg_r[1];
      `MSD_SFR_SER1_BUF: d = sbuf_r[1];
      `MSD_SFR_CORE_PWR: d = cpwr_r;
      `MSD_SFR_EXT_PWR:  d = epwr_r;
      default: begin
        for (int i = 0; i < 3; i++) begin
          if (a == `MSD_SFR_TMR_BASE + 8'(2 * i)) d = tmr_r[i][7:0];
          if (a == `MSD_SFR_TMR_BASE + 8'(2 * i + 1)) d = tmr_r[i][15:8];
        end
      end
    endcase
    return d;
  endfunction

  // only byte-aligned registers listed here take bit operations
  function automatic logic bit_sfr(input logic [7:0] a);
    return a inside {`MSD_SFR_GPIO0, `MSD_SFR_GPIO1, `MSD_SFR_GPIO2, `MSD_SFR_TMR_CTL,
                     `MSD_SFR_SER0_CFG, `MSD_SFR_IRQ_PRIO};
  endfunction

  // bit writes to ports change the output latch; byte reads still see the pins
  function automatic logic [7:0] rmw_read(input logic [7:0] a);
    case (a)
      `MSD_SFR_GPIO0: return gpio_r[7:0];
      `MSD_SFR_GPIO1: return gpio_r[15:8];
      `MSD_SFR_GPIO2: return {4'h0, gpio_r[19:16]};
      default:        return sfr_read(a);
    endcase
  endfunction

  function automatic logic [7:0] bit_put(input logic [7:0] b, input logic [2:0] p,
                                         input logic v);
    logic [7:0] r;
    r = b;
    r[p] = v;
    return r;
  endfunction

  // supply interrupt above both tiers, then high tier, lowest source first
  function automatic msd_pkg::msd_irq_t irq_pick(input logic [7:0] req, input logic [7:0] pr,
                                                 input logic sup);
    msd_pkg::msd_irq_t q;
    q = '0;
    for (int i = 7; i >= 0; i--) begin
      if (req[i] && !pr[i]) q = '{valid: 1'b1, tier: 2'h0, src: 3'(i)};
    end
    for (int i = 7; i >= 0; i--) begin
      if (req[i] && pr[i]) q = '{valid: 1'b1, tier: 2'h1, src: 3'(i)};
    end
    if (sup) q = '{valid: 1'b1, tier: 2'h2, src: 3'h0};
    return q;
  endfunction

  assign take     = i_req.valid && o_ready;
  assign o_ready  = (state_r == msd_pkg::MSD_ST_IDLE);
  assign sfr_byte = {i_req.addr[7:3], 3'h0};

  // request routing by addressing mode; ram bit writes take a second cycle
  always_comb begin
    ram_en = 1'b0;
    ram_we = 1'b0;
    ram_addr = i_req.addr[7:0];
    ram_wd = i_req.wdata;
    extended_ram_en = 1'b0;
    extended_ram_we = 1'b0;
    code_en = 1'b0;
    sfr_we = 1'b0;
    sfr_wa = i_req.addr[7:0];
    sfr_wd = i_req.wdata;
    state_nxt = state_r;
    pend_addr_nxt = pend_addr_r;
    pend_pos_nxt = pend_pos_r;
    pend_val_nxt = pend_val_r;
    rsp_valid_nxt = 1'b0;
    rsp_src_nxt = rsp_src_r;
    rsp_bit_nxt = rsp_bit_r;
    rsp_pos_nxt = rsp_pos_r;
    rsp_reg_nxt = rsp_reg_r;
    case (state_r)
      msd_pkg::MSD_ST_IDLE: begin
        if (take) begin
          rsp_valid_nxt = !i_req.write;
          rsp_bit_nxt = (i_req.mode == msd_pkg::MSD_BIT);
          rsp_pos_nxt = i_req.addr[2:0];
          rsp_src_nxt = SRC_REG;
          rsp_reg_nxt = 8'h00; // unmapped reads answer zero
          case (i_req.mode)
            msd_pkg::MSD_DIRECT: begin
              if (i_req.addr[7]) begin
                sfr_we = i_req.write; // upper half goes to sfrs only
                rsp_reg_nxt = sfr_read(i_req.addr[7:0]);
              end else begin
                ram_en = 1'b1; // lower half shared with indirect
                ram_we = i_req.write;
                rsp_src_nxt = SRC_IRAM;
              end
            end
            msd_pkg::MSD_INDIRECT: begin
              ram_en = 1'b1; // whole 256 bytes, upper half never sfr
              ram_we = i_req.write;
              rsp_src_nxt = SRC_IRAM;
            end
            msd_pkg::MSD_BIT: begin
              if (!i_req.addr[7]) begin
                ram_en = 1'b1;
                ram_addr = `MSD_BITRAM_BASE + {4'h0, i_req.addr[6:3]};
                rsp_src_nxt = SRC_IRAM;
                if (i_req.write) begin
                  state_nxt = msd_pkg::MSD_ST_BITWR;
                  pend_addr_nxt = ram_addr;
                  pend_pos_nxt = i_req.addr[2:0];
                  pend_val_nxt = i_req.wdata[0];
                end
              end else if (bit_sfr(sfr_byte)) begin
                sfr_wa = sfr_byte; // no masking needed by software
                sfr_wd = bit_put(rmw_read(sfr_byte), i_req.addr[2:0], i_req.wdata[0]);
                sfr_we = i_req.write;
                rsp_reg_nxt = sfr_read(sfr_byte);
              end
            end
            msd_pkg::MSD_EXT: begin
              if (i_req.addr[15:`MSD_EXTENDED_RAM_AW] == '0) begin
                extended_ram_en = 1'b1; // only extended modes reach this ram
                extended_ram_we = i_req.write;
                rsp_src_nxt = SRC_EXTENDED_RAM;
              end
            end
            msd_pkg::MSD_CODE: begin
              if (!i_req.write && i_req.addr < `MSD_CODE_LIMIT) begin
                code_en = 1'b1; // read only from the core side
                rsp_src_nxt = SRC_CODE;
              end
            end
            default: begin
            end
          endcase
        end
      end
      msd_pkg::MSD_ST_BITWR: begin
        ram_en = 1'b1; // write back the byte read last cycle
        ram_we = 1'b1;
        ram_addr = pend_addr_r;
        ram_wd = bit_put(iram_rd, pend_pos_r, pend_val_r);
        state_nxt = msd_pkg::MSD_ST_IDLE;
      end
      default: state_nxt = msd_pkg::MSD_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      state_r <= msd_pkg::MSD_ST_IDLE;
      pend_addr_r <= 8'h00;
      pend_pos_r <= 3'h0;
      pend_val_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_src_r <= SRC_REG;
      rsp_bit_r <= 1'b0;
      rsp_pos_r <= 3'h0;
      rsp_reg_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      pend_addr_r <= pend_addr_nxt;
      pend_pos_r <= pend_pos_nxt;
      pend_val_r <= pend_val_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_src_r <= rsp_src_nxt;
      rsp_bit_r <= rsp_bit_nxt;
      rsp_pos_r <= rsp_pos_nxt;
      rsp_reg_r <= rsp_reg_nxt;
    end
  end

  // answer one cycle after the request; bit reads return the bit in data[0]
  always_comb begin
    case (rsp_src_r)
      SRC_IRAM: rsp_byte = iram_rd;
      SRC_EXTENDED_RAM: rsp_byte = extended_ram_rd;
      SRC_CODE: rsp_byte = code_rd;
      default:  rsp_byte = rsp_reg_r;
    endcase
    o_rsp.valid = rsp_valid_r;
    o_rsp.data = rsp_bit_r ? {7'h00, rsp_byte[rsp_pos_r]} : rsp_byte;
  end

  msd_ram #(.DEPTH(`MSD_IRAM_BYTES), .AW(8)) u_iram (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_en(ram_en), .i_we(ram_we),
    .i_addr(ram_addr), .i_wdata(ram_wd), .o_rdata(iram_rd));

  msd_ram #(.DEPTH(`MSD_EXTENDED_RAM_BYTES), .AW(`MSD_EXTENDED_RAM_AW)) u_extended_ram (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_en(extended_ram_en), .i_we(extended_ram_we),
    .i_addr(i_req.addr[`MSD_EXTENDED_RAM_AW-1:0]), .i_wdata(i_req.wdata), .o_rdata(extended_ram_rd));

  // the loader owns the code store while it writes; a core read then is lost
  msd_ram #(.DEPTH(`MSD_CODE_BYTES), .AW(16)) u_code (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_en(code_en || i_code_load.valid),
    .i_we(i_code_load.valid && i_code_load.addr < `MSD_CODE_LIMIT),
    .i_addr(i_code_load.valid ? i_code_load.addr : i_req.addr),
    .i_wdata(i_code_load.data), .o_rdata(code_rd));

  // pins pass two flops; third stage feeds the edge detectors only
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      s1_r <= 24'h00_0000;
      s2_r <= 24'h00_0000;
      s3_r <= 4'h0;
    end else begin
      s1_r <= {i_cap_trig, i_tmr_evt, i_gpio_in};
      s2_r <= s1_r;
      s3_r <= s2_r[23:20];
    end
  end
  assign edge_s = s2_r[23:20] & ~s3_r;

  // peripheral sfrs: timers, capture, ports, serial, priority, power
  always_comb begin
    gpio_nxt = gpio_r;
    pu_nxt = pu_r;
    tctl_nxt = tctl_r;
    prio_nxt = prio_r;
    cpwr_nxt = cpwr_r;
    epwr_nxt = epwr_r;
    cap_nxt = cap_r;
    scfg_nxt = scfg_r;
    sbuf_nxt = sbuf_r;
    tx_nxt = '0;
    for (int i = 0; i < 3; i++) begin
      tmr_nxt[i] = tmr_r[i];
      if (tctl_r[`MSD_TC_RUN_LSB + i] && (!tctl_r[`MSD_TC_EVT_LSB + i] || edge_s[i])) begin
        tmr_nxt[i] = tmr_r[i] + 16'h0001; // clock or event counting
      end
      if (sfr_we && sfr_wa == `MSD_SFR_TMR_BASE + 8'(2 * i)) tmr_nxt[i][7:0] = sfr_wd;
      if (sfr_we && sfr_wa == `MSD_SFR_TMR_BASE + 8'(2 * i + 1)) tmr_nxt[i][15:8] = sfr_wd;
    end
    if (tctl_r[`MSD_TC_CAP_BIT] && edge_s[3]) cap_nxt = tmr_r[2];
    if (sfr_we) begin
      case (sfr_wa)
        `MSD_SFR_GPIO0:    gpio_nxt[7:0] = sfr_wd;
        `MSD_SFR_GPIO1:    gpio_nxt[15:8] = sfr_wd;
        `MSD_SFR_GPIO2:    gpio_nxt[19:16] = sfr_wd[3:0];
        `MSD_SFR_PU0:      pu_nxt[7:0] = sfr_wd;
        `MSD_SFR_PU1:      pu_nxt[15:8] = sfr_wd;
        `MSD_SFR_PU2:      pu_nxt[19:16] = sfr_wd[3:0];
        `MSD_SFR_TMR_CTL:  tctl_nxt = sfr_wd;
        `MSD_SFR_IRQ_PRIO: prio_nxt = sfr_wd;
        `MSD_SFR_CORE_PWR: cpwr_nxt = sfr_wd; // byte writes only reach it
        `MSD_SFR_EXT_PWR:  epwr_nxt = sfr_wd;
        `MSD_SFR_SER0_CFG: scfg_nxt[0] = sfr_wd;
        `MSD_SFR_SER1_CFG: scfg_nxt[1] = sfr_wd;
        `MSD_SFR_SER0_BUF: tx_nxt = '{valid: 1'b1, port: 1'b0, data: sfr_wd};
        `MSD_SFR_SER1_BUF: tx_nxt = '{valid: 1'b1, port: 1'b1, data: sfr_wd};
        default: begin
        end
      endcase
    end
    if (tx_nxt.valid) sbuf_nxt[tx_nxt.port] = tx_nxt.data;
    if (i_ser_rx.valid) sbuf_nxt[i_ser_rx.port] = i_ser_rx.data; // receive wins
    irq_nxt = irq_pick(i_irq_req, prio_r, i_supply_irq);
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      gpio_r <= `MSD_GPIO_RST;
      pu_r <= `MSD_PU_RST;
      tctl_r <= 8'h00;
      prio_r <= 8'h00;
      cpwr_r <= `MSD_CORE_PWR_RST;
      epwr_r <= `MSD_EXT_PWR_RST;
      cap_r <= 16'h0000;
      tmr_r <= '{default: 16'h0000};
      scfg_r <= '{default: 8'h00};
      sbuf_r <= '{default: 8'h00};
      tx_r <= '0;
      irq_r <= '0;
    end else begin
      gpio_r <= gpio_nxt;
      pu_r <= pu_nxt;
      tctl_r <= tctl_nxt;
      prio_r <= prio_nxt;
      cpwr_r <= cpwr_nxt;
      epwr_r <= epwr_nxt;
      cap_r <= cap_nxt;
      tmr_r <= tmr_nxt;
      scfg_r <= scfg_nxt;
      sbuf_r <= sbuf_nxt;
      tx_r <= tx_nxt;
      irq_r <= irq_nxt;
    end
  end

  // pins only ever carry port data, never a memory bus
  assign o_gpio_out    = gpio_r;
  assign o_gpio_oe_b   = gpio_r; // drive low for a 0, release for a 1
  assign o_gpio_pullup = pu_r & gpio_r;
  assign o_ser_cfg     = {scfg_r[1], scfg_r[0]};
  assign o_ser_tx      = tx_r;
  assign o_irq         = irq_r;
  assign o_core_pwr    = cpwr_r;
  assign o_ext_pwr     = epwr_r;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  AST_DIRECT_UPPER_SFR: assert property (
    take && i_req.mode == msd_pkg::MSD_DIRECT && i_req.addr[7] |-> !ram_en && !extended_ram_en)
    else $error("direct upper access reached ram");
  AST_INDIRECT_UPPER_RAM: assert property (
    take && i_req.mode == msd_pkg::MSD_INDIRECT |-> ram_en && ram_addr == i_req.addr[7:0]
    && !sfr_we) else $error("indirect access missed ram");
  AST_LOWER_SHARED: assert property (
    take && i_req.mode == msd_pkg::MSD_DIRECT && !i_req.addr[7] |-> ram_en
    && ram_addr == i_req.addr[7:0]) else $error("direct lower access missed ram");
  AST_BIT_MAP: assert property (
    take && i_req.mode == msd_pkg::MSD_BIT && !i_req.addr[7] && i_req.write
    |-> ram_addr == 8'h20 + {4'h0, i_req.addr[6:3]} ##1 ram_we
    && ram_wd[$past(i_req.addr[2:0])] == $past(i_req.wdata[0]) ##1 o_ready)
    else $error("bit write mapped wrong");
  AST_EXTENDED_RAM_ONLY_EXT: assert property (
    extended_ram_en |-> take && i_req.mode == msd_pkg::MSD_EXT && i_req.addr < 16'h0800)
    else $error("extended ram reached by other mode");
  AST_CORE_PWR_WRITE: assert property (
    take && i_req.write && i_req.mode == msd_pkg::MSD_DIRECT && i_req.addr == 16'h0087
    |=> o_core_pwr == $past(i_req.wdata)) else $error("core power write lost");
  AST_EXT_PWR_WRITE: assert property (
    take && i_req.write && i_req.mode == msd_pkg::MSD_DIRECT && i_req.addr == 16'h00c5
    |=> o_ext_pwr == $past(i_req.wdata)) else $error("extended power write lost");
  AST_UNMAPPED_ZERO: assert property (
    take && !i_req.write && i_req.mode == msd_pkg::MSD_DIRECT && i_req.addr == 16'h00ff
    |=> o_rsp.valid && o_rsp.data == 8'h00) else $error("unmapped read not zero");
  AST_CAPTURE: assert property (
    tctl_r[7] && edge_s[3] |=> cap_r == $past(tmr_r[2])) else $error("capture missed");
  AST_SUPPLY_TOP: assert property (
    i_supply_irq |=> o_irq.valid && o_irq.tier == 2'h2) else $error("supply irq not top");
  AST_CODE_READ_ONLY: assert property (
    take && i_req.mode == msd_pkg::MSD_CODE && i_req.write |-> !code_en)
    else $error("core wrote code store");

  COV_BIT_RMW: cover property (take && i_req.mode == msd_pkg::MSD_BIT && i_req.write
    ##2 o_ready);
  COV_EXTENDED_RAM_READ: cover property (take && i_req.mode == msd_pkg::MSD_EXT ##1 o_rsp.valid);
  COV_CAPTURE: cover property (tctl_r[7] && edge_s[3]);
endmodule
`default_nettype wire

// [src/msd_params.svh]
// constants for the core memory-space decoder: offsets, field positions,
// reset values and sizes; included by the package users, definitions only
`ifndef MSD_PARAMS_SVH
`define MSD_PARAMS_SVH

// memory sizes
`define MSD_IRAM_BYTES   256
`define MSD_EXTENDED_RAM_BYTES   2048
`define MSD_EXTENDED_RAM_AW      11
`define MSD_CODE_BYTES   63488
`define MSD_CODE_LIMIT   16'hf800
`define MSD_BITRAM_BASE  8'h20

// special function register offsets (internal direct space)
`define MSD_SFR_GPIO0    8'h80
`define MSD_SFR_CORE_PWR 8'h87
`define MSD_SFR_TMR_CTL  8'h88
`define MSD_SFR_TMR_BASE 8'h8a
`define MSD_SFR_GPIO1    8'h90
`define MSD_SFR_SER0_CFG 8'h98
`define MSD_SFR_SER0_BUF 8'h99
`define MSD_SFR_GPIO2    8'ha0
`define MSD_SFR_IRQ_PRIO 8'hb8
`define MSD_SFR_EXT_PWR  8'hc5
`define MSD_SFR_CAP_LO   8'hca
`define MSD_SFR_CAP_HI   8'hcb
`define MSD_SFR_PU0      8'hd9
`define MSD_SFR_PU1      8'hda
`define MSD_SFR_PU2      8'hdb
`define MSD_SFR_SER1_CFG 8'hea
`define MSD_SFR_SER1_BUF 8'heb

// timer control fields
`define MSD_TC_RUN_LSB   0
`define MSD_TC_EVT_LSB   4
`define MSD_TC_CAP_BIT   7

// reset values
`define MSD_CORE_PWR_RST 8'h00
`define MSD_EXT_PWR_RST  8'h00
`define MSD_GPIO_RST     20'hf_ffff
`define MSD_PU_RST       20'hf_ffff

`endif

// [src/msd_pkg.sv]
// types shared by the memory-space decoder and its users
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package msd_pkg;
  // addressing mode of a core access
  typedef enum logic [2:0] {
    MSD_DIRECT   = 3'h0,
    MSD_INDIRECT = 3'h1,
    MSD_BIT      = 3'h2,
    MSD_EXT      = 3'h3,
    MSD_CODE     = 3'h4
  } msd_mode_t;

  typedef enum logic [1:0] {
    MSD_ST_IDLE  = 2'h1,
    MSD_ST_BITWR = 2'h2
  } msd_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    msd_mode_t   mode;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } msd_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } msd_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
  } msd_load_t;

  typedef struct packed {
    logic       valid;
    logic       port;
    logic [7:0] data;
  } msd_ser_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] tier;
    logic [2:0] src;
  } msd_irq_t;
endpackage
`default_nettype wire

// [src/msd_ram.sv]
// single-port byte memory with registered read data
// assumes one clock, synchronous active-low reset on the read register only
`default_nettype none
module msd_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          i_mclk,
  input  wire logic          i_rst_b,
  input  wire logic          i_en,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [7:0]    i_wdata,
  output logic      [7:0]    o_rdata
);
  logic [7:0] mem [DEPTH];

  // contents carry no reset; caller keeps i_addr below DEPTH
  always_ff @(posedge i_mclk) begin
    if (i_en && i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  // read data register
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_en && !i_we) begin
      o_rdata <= mem[i_addr];
    end
  end
endmodule
`default_nettype wire

// [verif/msd_core_model.sv]
// core-side request model: issues one access at a time on the decoder bus
// assumes the decoder takes a request on a rising edge with ready high
`default_nettype none
module msd_core_model (
  input  wire logic              i_mclk,
  input  wire logic              i_ready,
  input  wire msd_pkg::msd_rsp_t i_rsp,
  output var msd_pkg::msd_req_t  o_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idle from time zero so nothing is taken during reset
  initial o_req = '0;

  // hold the request until ready is seen, then wait a bounded time for read data
  task automatic access(input logic w, input logic [2:0] md, input logic [15:0] ad,
                        input logic [7:0] wd, output logic [7:0] rd, output logic ok);
    int n;
    rd = 8'h00;
    @(posedge i_mclk);
    o_req <= '{1'b1, w, msd_pkg::msd_mode_t'(md), ad, wd};
    // ready is looked at mid-cycle, where it has settled
    @(negedge i_mclk);
    for (n = 0; n < 20 && i_ready !== 1'b1; n++) @(negedge i_mclk);
    ok = (i_ready === 1'b1);
    if (!ok) return;
    @(posedge i_mclk);
    o_req.valid <= 1'b0;
    if (!w) begin
      @(negedge i_mclk);
      if (i_rsp.valid !== 1'b1) @(negedge i_mclk);
      ok = (i_rsp.valid === 1'b1);
      rd = i_rsp.data;
    end
  endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the memory-space decoder, driven through the core model
// assumes the decoder package and header are compiled first
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic               mclk;
  logic               rst_b;
  logic               supply_irq;
  logic               ready;
  logic        [19:0] gpio_in;
  logic        [19:0] gpio_out;
  logic        [19:0] gpio_oe_b;
  logic        [7:0]  core_pwr;
  logic        [7:0]  ext_pwr;
  logic        [7:0]  rd;
  logic        [19:0] gpio_pull;
  logic        [15:0] ser_cfg;
  logic        [7:0]  irq_req;
  logic        [2:0]  tmr_evt;
  logic               cap_trig;
  msd_pkg::msd_ser_t  ser_rx;
  msd_pkg::msd_ser_t  ser_tx;
  msd_pkg::msd_req_t  req;
  msd_pkg::msd_rsp_t  rsp;
  msd_pkg::msd_load_t load;
  msd_pkg::msd_irq_t  irq;
  int                 fails;
  int                 n_checks;

  // every peripheral input is driven so each rule gets stimulus
  msd_decoder uut (
    .i_mclk(mclk), .i_rst_b(rst_b), .i_req(req), .o_ready(ready), .o_rsp(rsp),
    .i_code_load(load), .i_gpio_in(gpio_in), .o_gpio_out(gpio_out),
    .o_gpio_oe_b(gpio_oe_b), .o_gpio_pullup(gpio_pull), .i_tmr_evt(tmr_evt),
    .i_cap_trig(cap_trig), .i_irq_req(irq_req), .i_supply_irq(supply_irq), .o_irq(irq),
    .i_ser_rx(ser_rx), .o_ser_tx(ser_tx), .o_ser_cfg(ser_cfg), .o_core_pwr(core_pwr),
    .o_ext_pwr(ext_pwr)
  );
  msd_core_model core (.i_mclk(mclk), .i_ready(ready), .i_rsp(rsp), .o_req(req));

  task automatic end_of_test();
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // modes: 0 direct, 1 indirect, 2 bit, 3 extended, 4 code
  task automatic acc(input logic w, input logic [2:0] md, input logic [15:0] ad,
                     input logic [7:0] wd);
    logic ok;
    core.access(w, md, ad, wd, rd, ok);
    if (!ok) begin
      fails++;
      end_of_test();
    end
  endtask
  task automatic rdc(input logic [2:0] md, input logic [15:0] ad, input logic [7:0] e);
    acc(1'b0, md, ad, 8'h00);
    `CHK("read data", e, rd)
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    rst_b = 1'b0;
    supply_irq = 1'b0;
    gpio_in = 20'h0_0000;
    irq_req = 8'h00;
    tmr_evt = 3'h0;
    cap_trig = 1'b0;
    ser_rx = '0;
    load = '0;
    fails = 0;
    n_checks = 0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    `CHK("core_pwr", 8'h00, core_pwr)
    `CHK("gpio_out", 20'hf_ffff, gpio_out)
    // same low byte through both modes, upper half split by mode
    acc(1'b1, 3'h0, 16'h0030, 8'h5a);
    rdc(3'h1, 16'h0030, 8'h5a);
    acc(1'b1, 3'h1, 16'h0087, 8'hc3);
    acc(1'b1, 3'h0, 16'h0087, 8'h33);
    acc(1'b1, 3'h0, 16'h00c5, 8'h5c);
    rdc(3'h0, 16'h0087, 8'h33);
    rdc(3'h1, 16'h0087, 8'hc3);
    `CHK("core_pwr", 8'h33, core_pwr)
    `CHK("ext_pwr", 8'h5c, ext_pwr)
    acc(1'b1, 3'h1, 16'h00ff, 8'h9e);
    acc(1'b1, 3'h0, 16'h00ff, 8'h12);
    rdc(3'h1, 16'h00ff, 8'h9e);
    rdc(3'h0, 16'h00ff, 8'h00);
    // ram bit writes: bit 0x0b and the last bit of the area, busy cycle checked after the first
    acc(1'b1, 3'h0, 16'h0021, 8'h00);
    acc(1'b1, 3'h2, 16'h000b, 8'h01);
    @(negedge mclk);
    `CHK("ready", 1'b0, ready)
    rdc(3'h0, 16'h0021, 8'h08);
    rdc(3'h2, 16'h000b, 8'h01);
    acc(1'b1, 3'h1, 16'h002f, 8'h00);
    acc(1'b1, 3'h2, 16'h007f, 8'h01);
    rdc(3'h1, 16'h002f, 8'h80);
    // bit write into a port latch drives that pin low
    acc(1'b1, 3'h2, 16'h0080, 8'h00);
    @(negedge mclk);
    `CHK("gpio_out", 20'hf_fffe, gpio_out)
    `CHK("gpio_oe_b", 20'hf_fffe, gpio_oe_b)
    `CHK("gpio_pullup", 20'hf_fffe, gpio_pull)
    acc(1'b1, 3'h0, 16'h00d9, 8'h00);
    @(negedge mclk);
    `CHK("gpio_pullup", 20'hf_ff00, gpio_pull)
    // serial: a buffer write pulses transmit, a receive overwrites the buffer
    acc(1'b1, 3'h0, 16'h00eb, 8'h6b);
    @(negedge mclk);
    `CHK("ser_tx", 10'h36b, ser_tx)
    acc(1'b1, 3'h0, 16'h00ea, 8'h3c);
    @(negedge mclk);
    `CHK("ser_cfg", 16'h3c00, ser_cfg)
    rdc(3'h0, 16'h00eb, 8'h6b);
    @(posedge mclk);
    ser_rx <= '{1'b1, 1'b0, 8'hd2};
    @(posedge mclk);
    ser_rx.valid <= 1'b0;
    rdc(3'h0, 16'h0099, 8'hd2);
    // timer 2 counts three event edges, then the capture input copies it
    acc(1'b1, 3'h0, 16'h0088, 8'hc4);
    repeat (3) begin
      @(posedge mclk);
      tmr_evt <= 3'h4;
      @(posedge mclk);
      tmr_evt <= 3'h0;
    end
    repeat (3) @(posedge mclk);
    cap_trig <= 1'b1;
    rdc(3'h0, 16'h008e, 8'h03);
    rdc(3'h0, 16'h00ca, 8'h03);
    // extended space is its own memory and ends at 0x7ff
    acc(1'b1, 3'h3, 16'h07ff, 8'ha5);
    acc(1'b1, 3'h3, 16'h00ff, 8'h44);
    rdc(3'h3, 16'h07ff, 8'ha5);
    rdc(3'h1, 16'h00ff, 8'h9e);
    rdc(3'h3, 16'h0800, 8'h00);
    // code store: loaded from outside, core writes ignored, top 2 kB absent
    @(posedge mclk);
    load <= '{1'b1, 16'h1234, 8'h77};
    @(posedge mclk);
    load <= '{1'b1, 16'hf800, 8'h66};
    @(posedge mclk);
    load.valid <= 1'b0;
    acc(1'b1, 3'h4, 16'h1234, 8'h00);
    rdc(3'h4, 16'h1234, 8'h77);
    rdc(3'h4, 16'hf800, 8'h00);
    // pins seen through the synchronisers
    @(posedge mclk);
    gpio_in <= 20'h5_a53c;
    repeat (3) @(posedge mclk);
    rdc(3'h0, 16'h0090, 8'ha5);
    rdc(3'h0, 16'h0080, 8'h3c);
    // high tier source wins over a lower index in the low tier
    acc(1'b1, 3'h0, 16'h00b8, 8'h04);
    @(posedge mclk);
    irq_req <= 8'h06;
    @(negedge mclk);
    @(negedge mclk);
    `CHK("irq_high", 6'h2a, irq)
    // supply interrupt outranks both ordinary tiers
    @(posedge mclk);
    supply_irq <= 1'b1;
    @(negedge mclk);
    @(negedge mclk);
    `CHK("irq_tier", 2'h2, irq.tier)
    end_of_test();
  end
endmodule
`default_nettype wire
